// ---- hw/gdi_pkg.sv ----
// Constants and types for the instrument bus device port
// Function
// [R1] Serial poll while talk addressed puts the 8-bit status byte on data lines
// [R2] While service request is driven, status byte bit 6 and cause bit are set
// [R3] Status bits latch; clear after cause gone and byte read, or on clear status
// [R4] Parallel poll drives status bit on the configured data line only
// [R5] Interface clear drops talker and listener addressing at once
// [R6] Remote state blocks most front panel keys, displays keep updating
// [R7] Listener acts on data, trigger, clear, remote, local; talker sends data or status
// [R8] Clear, lockout, set local, abort act unaddressed; service request any time
// [R9] Remote entered by own listen address received while remote enable true
// [R10] Going remote lights remote indicator and keeps all control settings
// [R11] Go to local command or remote enable false always returns to local; the code obeys go to local only while listen addressed
// [R12] Front panel local key returns to local only without lockout
// [R13] Local lockout disables the local key; only bus commands return local
// [R14] Bytes are addresses or commands only with attention true, clear false
// [R15] Talk or listen indicator lights whenever addressed, local or remote
// [R16] Bus address 40 means listen only without controller addressing
// [R17] Bus address 50 means talk only, sending whenever attention false
// [R18] Power on: local, unaddressed, masks cleared, free run, delay trigger, defaults
// [R19] Receive data when listening unless talk only; send unless listen only
// [R20] Data bytes move only while attention is false
// [R21] Local keeps full panel control, remote message and service requests work
// [R22] Service request only for conditions enabled in the request mask
// [R23] Remote enable false cancels lockout and returns to local together
package gdi_pkg;
  localparam logic [7:0] LISTEN_ONLY_ADDR = 8'h28;
  localparam logic [7:0] TALK_ONLY_ADDR = 8'h32;
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] ESE_RESET = 8'h00;
  localparam logic [7:0] SRM_RESET = 8'h00;
  localparam int RQS_BIT = 6;
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_PPC = 8'h05;
  localparam logic [7:0] CMD_GET = 8'h08;
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_PPU = 8'h15;
  localparam logic [7:0] CMD_SPE = 8'h18;
  localparam logic [7:0] CMD_SPD = 8'h19;
  localparam logic [7:0] CMD_UNL = 8'h3f;
  localparam logic [7:0] CMD_UNT = 8'h5f;
  localparam logic [2:0] LAG_BASE = 3'h1;
  localparam logic [2:0] TAG_BASE = 3'h2;
  localparam logic [3:0] PPE_BASE = 4'h6;
  localparam logic [3:0] PPD_CODE = 4'h7;
  localparam logic [4:0] COND_NONE = 5'h00;
  typedef enum logic [1:0] {TRIG_FREE_RUN, TRIG_HOLD, TRIG_SINGLE} gdi_trig_t;
endpackage : gdi_pkg

// ---- hw/gdi_port.sv ----
// Instrument bus device port: addressing, remote/local, polls
`timescale 1ns/10ps
module gdi_port (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Bus lines, true level, one byte handshake strobe
  input wire logic ATN,
  input wire logic IFC,
  input wire logic REN,
  input wire logic [7:0] DIO_IN,
  input wire logic DAV_STB,
  output logic [7:0] DIO_OUT,
  output logic [7:0] DIO_OE_N,
  output logic SRQ_OUT,
  output logic SRQ_OE_N,
  // Instrument side
  input wire logic [7:0] BUS_ADDR,
  input wire logic [4:0] COND,
  input wire logic CLEAR_STATUS,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_TAKEN,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  output logic TRIGGER,
  output logic DEV_CLEAR,
  // Software port
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Front panel
  input wire logic [7:0] KEYS,
  input wire logic LOCAL_KEY,
  output logic [7:0] KEYS_OK,
  output logic REMOTE_INDICATOR,
  output logic TALK_INDICATOR,
  output logic LISTEN_INDICATOR,
  output logic TRIGGER_WITH_DELAY_RESPONSE,
  output gdi_pkg::gdi_trig_t TRIG_MODE
);
  import gdi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic talk_q, listen_q, remote_q, lockout_q, spoll_q;
  logic [7:0] srm_q, stb_q, esr_q, ese_q;
  logic [3:0] pp_q;
  logic ppc_pend_q;
  logic [7:0] rdata_q;
  logic cmd, data_stb, lon, ton, my_lag, my_tag, other_tag;
  logic srq;

  assign lon = (BUS_ADDR == LISTEN_ONLY_ADDR); // [R16]
  assign ton = (BUS_ADDR == TALK_ONLY_ADDR); // [R17]
  assign cmd = DAV_STB && ATN && !IFC; // [R14]
  assign data_stb = DAV_STB && !ATN && !IFC; // [R20]
  assign my_lag = cmd && DIO_IN == {LAG_BASE, BUS_ADDR[4:0]};
  assign my_tag = cmd && DIO_IN == {TAG_BASE, BUS_ADDR[4:0]};
  assign other_tag = cmd && DIO_IN[7:5] == TAG_BASE && !my_tag;

  ////////////////////////////////////////////////////////////////////////////
  // Addressing
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      talk_q <= 1'b0; // [R18]
      listen_q <= 1'b0;
    end else if (IFC) begin
      talk_q <= 1'b0; // [R5]
      listen_q <= 1'b0;
    end else if (cmd) begin
      if (DIO_IN == CMD_UNL || my_tag)
        listen_q <= 1'b0;
      else if (my_lag)
        listen_q <= 1'b1;
      if (DIO_IN == CMD_UNT || other_tag || my_lag)
        talk_q <= 1'b0;
      else if (my_tag)
        talk_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remote and lockout
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      remote_q <= 1'b0; // [R18]
      lockout_q <= 1'b0;
    end else if (!REN) begin
      remote_q <= 1'b0; // [R11] [R23]
      lockout_q <= 1'b0;
    end else begin
      if (my_lag)
        remote_q <= 1'b1; // [R9] [R10] [R21]
      else if (cmd && DIO_IN == CMD_GTL && listen_q)
        remote_q <= 1'b0; // [R11] [R7]
      else if (LOCAL_KEY && !lockout_q)
        remote_q <= 1'b0; // [R12] [R13]
      if (cmd && DIO_IN == CMD_LLO)
        lockout_q <= 1'b1; // [R8]
    end
  end

  assign KEYS_OK = remote_q ? 8'h00 : KEYS; // [R6] [R21]
  assign REMOTE_INDICATOR = remote_q; // [R10]
  assign TALK_INDICATOR = talk_q || ton; // [R15]
  assign LISTEN_INDICATOR = listen_q || lon; // [R15]

  ////////////////////////////////////////////////////////////////////////////
  // Serial poll and parallel poll configuration
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      spoll_q <= 1'b0;
      pp_q <= 4'h0; // [R18]
      ppc_pend_q <= 1'b0;
    end else if (IFC) begin
      spoll_q <= 1'b0;
      ppc_pend_q <= 1'b0;
    end else if (cmd) begin
      if (DIO_IN == CMD_SPE)
        spoll_q <= 1'b1;
      else if (DIO_IN == CMD_SPD)
        spoll_q <= 1'b0;
      if (DIO_IN == CMD_PPU)
        pp_q <= 4'h0;
      ppc_pend_q <= (DIO_IN == CMD_PPC) && listen_q;
      if (ppc_pend_q && DIO_IN[7:4] == PPE_BASE)
        pp_q <= {1'b1, DIO_IN[2:0]};
      else if (ppc_pend_q && DIO_IN[7:4] == PPD_CODE)
        pp_q <= 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status byte
  logic stb_read;
  assign stb_read = data_stb && talk_q && spoll_q;
  assign srq = |(stb_q[4:0] & srm_q[4:0]); // [R22]

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      stb_q <= 8'h00; // [R18]
    end else begin
      if (CLEAR_STATUS)
        stb_q <= {3'h0, COND}; // [R3]
      else if (stb_read)
        stb_q <= {3'h0, (stb_q[4:0] & COND) | COND}; // [R3]
      else
        stb_q <= {3'h0, stb_q[4:0] | COND}; // [R3]
    end
  end

  assign SRQ_OUT = 1'b0;
  assign SRQ_OE_N = !srq; // [R8] [R22]

  ////////////////////////////////////////////////////////////////////////////
  // Data lines
  always_comb begin
    DIO_OUT = 8'h00;
    DIO_OE_N = 8'hff;
    if (ATN && pp_q[3] && !IFC) begin
      DIO_OUT[pp_q[2:0]] = srq; // [R4]
      DIO_OE_N[pp_q[2:0]] = !srq; // [R4]
    end else if (!ATN && talk_q && spoll_q && !lon) begin
      DIO_OUT = {stb_q[7], srq, stb_q[5:0]}; // [R1] [R2]
      DIO_OE_N = 8'h00;
    end else if (!ATN && (talk_q || ton) && !lon && TX_VALID) begin
      DIO_OUT = TX_DATA; // [R17] [R19]
      DIO_OE_N = 8'h00;
    end
  end
  assign TX_TAKEN = data_stb && (talk_q || ton) && !lon && TX_VALID &&
                    !(talk_q && spoll_q); // [R19]

  ////////////////////////////////////////////////////////////////////////////
  // Received data and device messages
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RX_DATA <= 8'h00;
      RX_VALID <= 1'b0;
      TRIGGER <= 1'b0;
      DEV_CLEAR <= 1'b0;
    end else begin
      RX_VALID <= data_stb && (listen_q || lon) && !ton; // [R19] [R7]
      if (data_stb && (listen_q || lon) && !ton)
        RX_DATA <= DIO_IN;
      TRIGGER <= cmd && DIO_IN == CMD_GET && listen_q; // [R7]
      DEV_CLEAR <= cmd && (DIO_IN == CMD_DCL ||
                   (DIO_IN == CMD_SDC && listen_q)); // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers: 0 mask, 1 event status, 2 event enable, 3 status on read, trigger mode and delay response on write
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      srm_q <= SRM_RESET; // [R18]
      esr_q <= ESR_RESET;
      ese_q <= ESE_RESET;
      TRIG_MODE <= TRIG_FREE_RUN;
      TRIGGER_WITH_DELAY_RESPONSE <= 1'b1;
    end else if (WR) begin
      case (ADDR)
        2'h0: srm_q <= WDATA;
        2'h1: esr_q <= WDATA;
        2'h2: ese_q <= WDATA;
        2'h3: begin
          TRIG_MODE <= gdi_trig_t'(WDATA[1:0]);
          TRIGGER_WITH_DELAY_RESPONSE <= WDATA[2];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST)
      rdata_q <= 8'h00;
    else if (RD) begin
      case (ADDR)
        2'h0: rdata_q <= srm_q;
        2'h1: rdata_q <= esr_q;
        2'h2: rdata_q <= ese_q;
        default: rdata_q <= {stb_q[7], srq, stb_q[5:0]};
      endcase
    end else
      rdata_q <= 8'h00;
  end
  assign RDATA = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_ifc_drop;
    @(posedge CLK) disable iff (!NRST) IFC |=> !talk_q && !listen_q;
  endproperty
  a_ifc_drop: assert property (p_ifc_drop) else $error("addr kept"); // [R5]

  property p_ren_low;
    @(posedge CLK) disable iff (!NRST) !REN |=> !remote_q && !lockout_q;
  endproperty
  a_ren_low: assert property (p_ren_low) else $error("remote kept"); // [R23]

  property p_remote_on;
    @(posedge CLK) disable iff (!NRST) REN && my_lag |=> REMOTE_INDICATOR;
  endproperty
  a_remote_on: assert property (p_remote_on) else $error("no remote"); // [R9]

  property p_lockout_key;
    @(posedge CLK) disable iff (!NRST)
      REN && lockout_q && remote_q && LOCAL_KEY && !cmd |=> remote_q;
  endproperty
  a_lockout_key: assert property (p_lockout_key) else $error("key"); // [R13]

  property p_keys_blocked;
    @(posedge CLK) disable iff (!NRST) remote_q |-> KEYS_OK == 8'h00;
  endproperty
  a_keys_blocked: assert property (p_keys_blocked) else $error("keys"); // [R6]

  property p_srq_bit6;
    @(posedge CLK) disable iff (!NRST)
      !SRQ_OE_N && !ATN && talk_q && spoll_q && !lon |-> DIO_OUT[RQS_BIT];
  endproperty
  a_srq_bit6: assert property (p_srq_bit6) else $error("bit6"); // [R2]

  property p_srq_mask;
    @(posedge CLK) disable iff (!NRST)
      (srm_q[4:0] == 5'h00) |-> SRQ_OE_N;
  endproperty
  a_srq_mask: assert property (p_srq_mask) else $error("srq"); // [R22]

  property p_latch;
    @(posedge CLK) disable iff (!NRST)
      stb_q[0] && !CLEAR_STATUS && !stb_read |=> stb_q[0];
  endproperty
  a_latch: assert property (p_latch) else $error("unlatched"); // [R3]

  property p_no_rx_cmd;
    @(posedge CLK) disable iff (!NRST) ATN |=> !RX_VALID;
  endproperty
  a_no_rx_cmd: assert property (p_no_rx_cmd) else $error("rx atn"); // [R20]

  property p_talk_only;
    @(posedge CLK) disable iff (!NRST)
      ton && !ATN && !IFC && TX_VALID |-> DIO_OE_N == 8'h00;
  endproperty
  a_talk_only: assert property (p_talk_only) else $error("ton"); // [R17]

  property p_pp_one;
    @(posedge CLK) disable iff (!NRST)
      ATN && !IFC |-> $countones(~DIO_OE_N) <= 1;
  endproperty
  a_pp_one: assert property (p_pp_one) else $error("pp lines"); // [R4]

  property p_pp_off;
    @(posedge CLK) disable iff (!NRST)
      ATN && !pp_q[3] |-> DIO_OE_N == 8'hff;
  endproperty
  a_pp_off: assert property (p_pp_off) else $error("pp off"); // [R4]

  property p_lon_quiet;
    @(posedge CLK) disable iff (!NRST)
      lon && !ATN |-> DIO_OE_N == 8'hff;
  endproperty
  a_lon_quiet: assert property (p_lon_quiet) else $error("lon"); // [R19]

  property p_ton_deaf;
    @(posedge CLK) disable iff (!NRST)
      ton |=> !RX_VALID;
  endproperty
  a_ton_deaf: assert property (p_ton_deaf) else $error("ton rx"); // [R19]

  property p_ifc_quiet;
    @(posedge CLK) disable iff (!NRST)
      IFC |=> !TRIGGER && !DEV_CLEAR;
  endproperty
  a_ifc_quiet: assert property (p_ifc_quiet) else $error("ifc"); // [R14]

  property p_gtl;
    @(posedge CLK) disable iff (!NRST)
      REN && cmd && DIO_IN == CMD_GTL && listen_q |=> !REMOTE_INDICATOR;
  endproperty
  a_gtl: assert property (p_gtl) else $error("gtl"); // [R11]

  property p_local_key;
    @(posedge CLK) disable iff (!NRST)
      REN && LOCAL_KEY && !lockout_q && !my_lag |=> !remote_q;
  endproperty
  a_local_key: assert property (p_local_key) else $error("lkey"); // [R12]

  property p_llo;
    @(posedge CLK) disable iff (!NRST)
      REN && cmd && DIO_IN == CMD_LLO |=> lockout_q;
  endproperty
  a_llo: assert property (p_llo) else $error("llo"); // [R8]

  property p_tag_ind;
    @(posedge CLK) disable iff (!NRST)
      my_tag && !lon |=> TALK_INDICATOR && !LISTEN_INDICATOR;
  endproperty
  a_tag_ind: assert property (p_tag_ind) else $error("ind"); // [R15]

  property p_cs;
    @(posedge CLK) disable iff (!NRST)
      CLEAR_STATUS |=> stb_q[4:0] == $past(COND);
  endproperty
  a_cs: assert property (p_cs) else $error("cs"); // [R3]

  property p_tx_taken;
    @(posedge CLK) disable iff (!NRST)
      TX_TAKEN |-> TX_VALID && !ATN && DIO_OE_N == 8'h00;
  endproperty
  a_tx_taken: assert property (p_tx_taken) else $error("taken"); // [R19]

  property p_spoll;
    @(posedge CLK) disable iff (!NRST) !ATN && talk_q && spoll_q && !lon
      |-> DIO_OUT[4:0] == stb_q[4:0] && DIO_OE_N == 8'h00;
  endproperty
  a_spoll: assert property (p_spoll) else $error("spoll"); // [R1]
endmodule : gdi_port

// ---- verification/gdi_ctrl_model.sv ----
// Bus controller model for the instrument bus port
`timescale 1ns/10ps
module gdi_ctrl_model (
  // Clock
  input wire logic CLK,
  // Bus lines toward the device
  output logic ATN,
  output logic IFC,
  output logic REN,
  output logic [7:0] DIO_IN,
  output logic DAV_STB
);
  initial begin
    {ATN, IFC, REN, DAV_STB} = 4'h0;
    DIO_IN = 8'h00;
  end
  // One byte; command only with attention true, clear false
  task automatic send(input logic atn, input logic [7:0] b);
    @(posedge CLK);
    ATN <= atn;
    DIO_IN <= b;
    DAV_STB <= 1'b1;
    @(posedge CLK);
    DAV_STB <= 1'b0;
    DIO_IN <= ~b;
  endtask : send
  // Attention and remote enable lines set on the next clock edge
  task automatic lines(input logic atn, input logic ren);
    @(posedge CLK);
    ATN <= atn;
    REN <= ren;
  endtask : lines
  task automatic abort;
    @(posedge CLK);
    IFC <= 1'b1;
    @(posedge CLK);
    IFC <= 1'b0;
  endtask : abort
endmodule : gdi_ctrl_model

// ---- verification/ieee488_device_interface_test.sv ----
// Self-checking bench for the instrument bus device port
`timescale 1ns/10ps
module ieee488_device_interface_test;
  import gdi_pkg::*;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic ATN, IFC, REN, DAV_STB, CLEAR_STATUS, TX_VALID, WR, RD, LOCAL_KEY;
  logic [7:0] DIO_IN, BUS_ADDR, TX_DATA, WDATA, KEYS;
  logic [4:0] COND;
  logic [1:0] ADDR;
  logic [7:0] DIO_OUT, DIO_OE_N, RX_DATA, RDATA, KEYS_OK;
  logic SRQ_OUT, SRQ_OE_N, TX_TAKEN, RX_VALID, TRIGGER, DEV_CLEAR;
  logic REMOTE_INDICATOR, TALK_INDICATOR, LISTEN_INDICATOR;
  logic TRIGGER_WITH_DELAY_RESPONSE;
  gdi_trig_t TRIG_MODE;
  int err_count = 0;
  int n_compared = 0;
  int n_taken = 0;
  always @(posedge CLK) begin
    if (TX_TAKEN) begin
      n_taken <= n_taken + 1;
    end
  end
  wire [7:0] st = {3'h0, REMOTE_INDICATOR, TALK_INDICATOR,
    LISTEN_INDICATOR, SRQ_OE_N, TRIGGER_WITH_DELAY_RESPONSE};
  always #50 CLK = ~CLK;
  gdi_ctrl_model m (.CLK, .ATN, .IFC, .REN, .DIO_IN, .DAV_STB);
  gdi_port DUT (.CLK, .NRST, .ATN, .IFC, .REN, .DIO_IN, .DAV_STB,
    .DIO_OUT, .DIO_OE_N, .SRQ_OUT, .SRQ_OE_N, .BUS_ADDR, .COND,
    .CLEAR_STATUS, .TX_DATA, .TX_VALID, .TX_TAKEN, .RX_DATA, .RX_VALID,
    .TRIGGER, .DEV_CLEAR, .ADDR, .WDATA, .WR, .RD, .RDATA, .KEYS,
    .LOCAL_KEY, .KEYS_OK, .REMOTE_INDICATOR, .TALK_INDICATOR,
    .LISTEN_INDICATOR, .TRIGGER_WITH_DELAY_RESPONSE, .TRIG_MODE);
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(RDATA, exp);
  endtask : rd
  task automatic press;
    @(posedge CLK);
    LOCAL_KEY <= 1'b1;
    @(posedge CLK);
    LOCAL_KEY <= 1'b0;
  endtask : press
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge CLK);
    err_count++;
    wrap_up;
  end
  initial begin
    {CLEAR_STATUS, TX_VALID, WR, RD, LOCAL_KEY} = 5'h00;
    {BUS_ADDR, TX_DATA, WDATA, KEYS} = {8'h0d, 8'h00, 8'h00, 8'h5a};
    COND = 5'h00;
    ADDR = 2'h0;
    repeat (2) @(posedge CLK);
    NRST <= 1'b1;
    #1 chk(st, 8'h03);
    chk(DIO_OE_N, 8'hff);
    chk({6'h0, TRIG_MODE}, {6'h0, TRIG_FREE_RUN});
    chk(KEYS_OK, 8'h5a);
    rd(2'h0, SRM_RESET);
    rd(2'h1, ESR_RESET);
    rd(2'h2, ESE_RESET);
    rd(2'h3, 8'h00);
    wr(2'h3, 8'h05);
    wr(2'h2, 8'h3c);
    m.lines(1'b1, 1'b1);
    m.send(1'b1, 8'h2d);
    #1 chk(st, 8'h17);
    chk(KEYS_OK, 8'h00);
    chk({6'h0, TRIG_MODE}, {6'h0, TRIG_HOLD});
    rd(2'h2, 8'h3c);
    m.send(1'b0, 8'h41);
    #1 chk({RX_VALID, RX_DATA[6:0]}, 8'hc1);
    m.send(1'b1, CMD_GET);
    #1 chk({7'h0, TRIGGER}, 8'h01);
    m.send(1'b1, CMD_LLO);
    press;
    #1 chk(st, 8'h17);
    m.lines(1'b1, 1'b0);
    tick(1);
    chk(st, 8'h07);
    m.lines(1'b1, 1'b1);
    m.send(1'b1, 8'h2d);
    press;
    #1 chk(st, 8'h07);
    m.send(1'b1, 8'h2d);
    m.send(1'b1, CMD_GTL);
    #1 chk(st, 8'h07);
    m.send(1'b1, CMD_UNL);
    m.send(1'b1, CMD_DCL);
    #1 chk({6'h0, DEV_CLEAR, LISTEN_INDICATOR}, 8'h02);
    m.send(1'b1, CMD_GET);
    #1 chk({7'h0, TRIGGER}, 8'h00);
    wr(2'h0, 8'h01);
    COND <= 5'h02;
    tick(2);
    chk({7'h0, SRQ_OE_N}, 8'h01);
    COND <= 5'h03;
    tick(2);
    chk({6'h0, SRQ_OUT, SRQ_OE_N}, 8'h00);
    m.send(1'b1, 8'h2d);
    m.send(1'b1, CMD_PPC);
    m.send(1'b1, 8'h63);
    #1 chk(DIO_OE_N, 8'hf7);
    chk(DIO_OUT, 8'h08);
    m.send(1'b1, CMD_PPU);
    #1 chk(DIO_OE_N, 8'hff);
    m.send(1'b1, CMD_GTL);
    m.send(1'b1, CMD_SPE);
    m.send(1'b1, 8'h4d);
    m.lines(1'b0, 1'b1);
    #1 chk(DIO_OUT, 8'h43);
    chk(DIO_OE_N, 8'h00);
    COND <= 5'h00;
    rd(2'h3, 8'h43);
    m.send(1'b0, 8'h00);
    #1 chk({SRQ_OE_N, DIO_OUT[6:0]}, 8'h80);
    rd(2'h3, 8'h00);
    m.send(1'b1, CMD_SPD);
    COND <= 5'h01;
    tick(2);
    COND <= 5'h00;
    rd(2'h3, 8'h41);
    @(posedge CLK);
    CLEAR_STATUS <= 1'b1;
    @(posedge CLK);
    CLEAR_STATUS <= 1'b0;
    rd(2'h3, 8'h00);
    chk({7'h0, TALK_INDICATOR}, 8'h01);
    m.abort;
    #1 chk(st, 8'h03);
    BUS_ADDR <= 8'h28;
    m.send(1'b0, 8'h37);
    #1 chk({RX_VALID, RX_DATA[6:0]}, 8'hb7);
    BUS_ADDR <= 8'h32;
    TX_DATA <= 8'ha5;
    TX_VALID <= 1'b1;
    tick(1);
    chk(DIO_OUT, 8'ha5);
    chk(DIO_OE_N, 8'h00);
    m.send(1'b0, 8'h5a);
    #1 chk(n_taken[7:0], 8'h01);
    wrap_up;
  end
endmodule : ieee488_device_interface_test
